// >>> core/spi_fifo_port_pkg.sv
// Package: register map, field layout and reset values of the FIFO port
`default_nettype none
package spi_fifo_port_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFF_FRAME_SHAPE = 8'h40;
  localparam logic [7:0] OFF_TX_PORT = 8'h48;
  localparam logic [7:0] OFF_RX_PORT = 8'h4c;
  localparam logic [7:0] OFF_TX_MARK = 8'h50;
  localparam logic [7:0] OFF_RX_MARK = 8'h54;
  localparam logic [7:0] OFF_LEVEL_STAT = 8'h74;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int LANE_LSB = 0;
  localparam int LSB_FIRST_BIT = 2;
  localparam int DIR_BIT = 3;
  localparam int LEN_LSB = 16;
  localparam int FLAG_BIT = 31;
  // ****************************************
  // Values
  // ****************************************
  localparam logic [1:0] LANES_SINGLE = 2'h0;
  localparam logic [1:0] LANES_DUAL = 2'h1;
  localparam logic [1:0] LANES_QUAD = 2'h2;
  localparam logic [3:0] LEN_MAX = 4'h8;
  localparam logic [2:0] TX_MARK_RST_FLASH = 3'h1;
  localparam logic [2:0] TX_MARK_RST_PLAIN = 3'h0;
  localparam logic [2:0] RX_MARK_RST = 3'h0;

  typedef struct packed {
    logic [3:0] len;
    logic dir_tx;
    logic lsb_first;
    logic [1:0] lanes;
  } frame_shape_t;

  typedef struct packed {
    logic [3:0] oe;
    logic [3:0] o;
  } io_drive_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW = 2'b01,
    ST_HIGH = 2'b11
  } shift_state_t;
endpackage
`default_nettype wire

// >>> core/spi_frame_format_fifo_port.sv
// Serial frame format, transmit/receive FIFOs and watermark levels
//
// Register access over APB was left to the implementer.
`default_nettype none
module spi_frame_format_fifo_port #(
  parameter bit FLASH_BUILD = 1'b1,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  // Bus clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial link from surrounding controller
  input wire logic sck_in,
  input wire logic frame_go,
  input wire logic flash_path,
  // Data lines
  input wire logic [3:0] io_line_i,
  output logic [3:0] io_line_o,
  output logic [3:0] io_line_oe,
  // Level conditions
  output logic tx_level,
  output logic rx_level
);
  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);

  // ****************************************
  // Registers
  // ****************************************
  spi_fifo_port_pkg::frame_shape_t shape_r;
  logic [2:0] tx_mark_r;
  logic [2:0] rx_mark_r;
  logic [7:0] tx_mem [DEPTH];
  logic [7:0] rx_mem [DEPTH];
  logic [AW:0] tx_cnt_r, rx_cnt_r;
  logic [AW-1:0] tx_rd_r, tx_wr_r, rx_rd_r, rx_wr_r;
  logic [1:0] sck_sync_r;
  logic sck_prev_r;
  spi_fifo_port_pkg::shift_state_t st_r;
  logic [7:0] sh_r;
  logic [3:0] bits_r;
  logic fmt_dir_r, fmt_lsb_r;
  logic [1:0] fmt_lanes_r;
  logic [3:0] fmt_len_r;
  spi_fifo_port_pkg::io_drive_t drv_nxt;

  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  // ****************************************
  // Bus decode
  // ****************************************
  wire acc = psel && penable && pready;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire tx_full = (tx_cnt_r == DEPTH_C);
  wire rx_empty = (rx_cnt_r == '0);
  wire tx_push = wr && hit(paddr, spi_fifo_port_pkg::OFF_TX_PORT)
    && !tx_full;
  wire rx_pop = rd && hit(paddr, spi_fifo_port_pkg::OFF_RX_PORT)
    && !rx_empty;
  wire mapped = hit(paddr, spi_fifo_port_pkg::OFF_FRAME_SHAPE)
    || hit(paddr, spi_fifo_port_pkg::OFF_TX_PORT)
    || hit(paddr, spi_fifo_port_pkg::OFF_RX_PORT)
    || hit(paddr, spi_fifo_port_pkg::OFF_TX_MARK)
    || hit(paddr, spi_fifo_port_pkg::OFF_RX_MARK)
    || hit(paddr, spi_fifo_port_pkg::OFF_LEVEL_STAT);

  // ****************************************
  // Serial clock edges
  // ****************************************
  // Link clock is far slower than pclk, so edge detect on synced copy
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sck_sync_r <= 2'h0;
      sck_prev_r <= 1'b0;
    end
    else
    begin
      sck_sync_r <= {sck_sync_r[0], sck_in};
      sck_prev_r <= sck_sync_r[1];
    end
  end
  wire sck_rise = sck_sync_r[1] && !sck_prev_r;
  wire sck_fall = !sck_sync_r[1] && sck_prev_r;

  // Lines sampled on rise; the rise and fall of one sck both land later
  logic [3:0] io_s1_r, io_s2_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      io_s1_r <= 4'h0;
      io_s2_r <= 4'h0;
    end
    else
    begin
      io_s1_r <= io_line_i;
      io_s2_r <= io_s1_r;
    end
  end

  // ****************************************
  // Frame shifter
  // ****************************************
  // Bits consumed per sck by lane count
  logic [3:0] step;
  always_comb
  begin
    step = 4'h1;
    if (fmt_lanes_r == spi_fifo_port_pkg::LANES_DUAL)
      step = 4'h2;
    else if (fmt_lanes_r == spi_fifo_port_pkg::LANES_QUAD)
      step = 4'h4;
  end
  wire tx_empty = (tx_cnt_r == '0);
  wire frame_done = (st_r == spi_fifo_port_pkg::ST_HIGH) && sck_fall
    && (bits_r <= step);
  wire start = (st_r == spi_fifo_port_pkg::ST_IDLE) && frame_go
    && !flash_path && !tx_empty;
  wire tx_pop = start;
  wire rx_push = frame_done && !fmt_dir_r
    && (rx_cnt_r != DEPTH_C);

  // Receive shift in, MSB-first moves up, LSB-first moves down
  function automatic logic [7:0] shift_in(input logic [7:0] s,
                                          input logic [3:0] d,
                                          input logic [3:0] n,
                                          input logic lsb);
    logic [7:0] r;
    r = s;
    if (n == 4'h1)
      r = lsb ? {d[1], s[7:1]} : {s[6:0], d[1]};
    else if (n == 4'h2)
      r = lsb ? {d[1:0], s[7:2]} : {s[5:0], d[1:0]};
    else
      r = lsb ? {d[3:0], s[7:4]} : {s[3:0], d[3:0]};
    shift_in = r;
  endfunction

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= spi_fifo_port_pkg::ST_IDLE;
      sh_r <= 8'h0;
      bits_r <= 4'h0;
      fmt_dir_r <= 1'b0;
      fmt_lsb_r <= 1'b0;
      fmt_lanes_r <= spi_fifo_port_pkg::LANES_SINGLE;
      fmt_len_r <= spi_fifo_port_pkg::LEN_MAX;
    end
    else
    begin
      case (st_r)
        spi_fifo_port_pkg::ST_IDLE:
          if (start)
          begin
            // Format latched per frame so a rewrite mid-frame is harmless
            sh_r <= tx_mem[tx_rd_r];
            bits_r <= shape_r.len;
            fmt_dir_r <= shape_r.dir_tx;
            fmt_lsb_r <= shape_r.lsb_first;
            fmt_lanes_r <= shape_r.lanes;
            fmt_len_r <= shape_r.len;
            st_r <= (shape_r.len == 4'h0) ? spi_fifo_port_pkg::ST_IDLE
              : spi_fifo_port_pkg::ST_LOW;
          end
        spi_fifo_port_pkg::ST_LOW:
          if (sck_rise)
          begin
            sh_r <= shift_in(sh_r, io_s2_r, step, fmt_lsb_r);
            st_r <= spi_fifo_port_pkg::ST_HIGH;
          end
        spi_fifo_port_pkg::ST_HIGH:
          if (sck_fall)
          begin
            bits_r <= (bits_r <= step) ? 4'h0 : bits_r - step;
            st_r <= (bits_r <= step) ? spi_fifo_port_pkg::ST_IDLE
              : spi_fifo_port_pkg::ST_LOW;
          end
        default: st_r <= spi_fifo_port_pkg::ST_IDLE;
      endcase
    end
  end

  // Line drive from lane mode and direction
  always_comb
  begin
    drv_nxt = '0;
    if (st_r != spi_fifo_port_pkg::ST_IDLE)
    begin
      if (fmt_lanes_r == spi_fifo_port_pkg::LANES_SINGLE)
      begin
        drv_nxt.oe = 4'h1;
        drv_nxt.o[0] = fmt_lsb_r ? sh_r[0] : sh_r[7];
      end
      else if (fmt_dir_r && fmt_lanes_r == spi_fifo_port_pkg::LANES_DUAL)
      begin
        drv_nxt.oe = 4'h3;
        drv_nxt.o[1:0] = fmt_lsb_r ? sh_r[1:0] : sh_r[7:6];
      end
      else if (fmt_dir_r && fmt_lanes_r == spi_fifo_port_pkg::LANES_QUAD)
      begin
        drv_nxt.oe = 4'hf;
        drv_nxt.o = fmt_lsb_r ? sh_r[3:0] : sh_r[7:4];
      end
    end
  end

  // ****************************************
  // FIFOs
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_cnt_r <= '0;
      tx_rd_r <= '0;
      tx_wr_r <= '0;
    end
    else
    begin
      if (tx_push)
      begin
        tx_mem[tx_wr_r] <= pwdata[7:0];
        tx_wr_r <= tx_wr_r + 1'b1;
      end
      if (tx_pop)
        tx_rd_r <= tx_rd_r + 1'b1;
      tx_cnt_r <= tx_cnt_r + (AW + 1)'(tx_push)
        - (AW + 1)'(tx_pop);
    end
  end

  // Short frames: LSB-first data sits at the top after shifting and is moved down; MSB-first is moved up on store
  wire [7:0] rx_word = fmt_lsb_r
    ? (sh_r >> (4'h8 - fmt_len_r)) : sh_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_cnt_r <= '0;
      rx_rd_r <= '0;
      rx_wr_r <= '0;
    end
    else
    begin
      if (rx_push)
      begin
        rx_mem[rx_wr_r] <= fmt_lsb_r ? rx_word
          : (sh_r << (4'h8 - fmt_len_r));
        rx_wr_r <= rx_wr_r + 1'b1;
      end
      if (rx_pop)
        rx_rd_r <= rx_rd_r + 1'b1;
      rx_cnt_r <= rx_cnt_r + (AW + 1)'(rx_push)
        - (AW + 1)'(rx_pop);
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shape_r.lanes <= spi_fifo_port_pkg::LANES_SINGLE;
      shape_r.lsb_first <= 1'b0;
      shape_r.dir_tx <= FLASH_BUILD;
      shape_r.len <= spi_fifo_port_pkg::LEN_MAX;
      tx_mark_r <= FLASH_BUILD ? spi_fifo_port_pkg::TX_MARK_RST_FLASH
        : spi_fifo_port_pkg::TX_MARK_RST_PLAIN;
      rx_mark_r <= spi_fifo_port_pkg::RX_MARK_RST;
    end
    else if (wr)
    begin
      if (hit(paddr, spi_fifo_port_pkg::OFF_FRAME_SHAPE))
      begin
        shape_r.lanes <= pwdata[spi_fifo_port_pkg::LANE_LSB +: 2];
        shape_r.lsb_first <= pwdata[spi_fifo_port_pkg::LSB_FIRST_BIT];
        shape_r.dir_tx <= pwdata[spi_fifo_port_pkg::DIR_BIT];
        // Lengths above 8 are clamped rather than stored
        shape_r.len <= (pwdata[spi_fifo_port_pkg::LEN_LSB +: 4]
          > spi_fifo_port_pkg::LEN_MAX) ? spi_fifo_port_pkg::LEN_MAX
          : pwdata[spi_fifo_port_pkg::LEN_LSB +: 4];
      end
      else if (hit(paddr, spi_fifo_port_pkg::OFF_TX_MARK))
        tx_mark_r <= pwdata[2:0];
      else if (hit(paddr, spi_fifo_port_pkg::OFF_RX_MARK))
        rx_mark_r <= pwdata[2:0];
    end
  end

  // ****************************************
  // Read data and outputs
  // ****************************************
  logic [31:0] rdata;
  always_comb
  begin
    rdata = 32'h0;
    if (hit(paddr, spi_fifo_port_pkg::OFF_FRAME_SHAPE))
      rdata = {12'h0, shape_r.len, 12'h0, shape_r.dir_tx,
        shape_r.lsb_first, shape_r.lanes};
    else if (hit(paddr, spi_fifo_port_pkg::OFF_TX_PORT))
      rdata[spi_fifo_port_pkg::FLAG_BIT] = tx_full;
    else if (hit(paddr, spi_fifo_port_pkg::OFF_RX_PORT))
    begin
      rdata[spi_fifo_port_pkg::FLAG_BIT] = rx_empty;
      rdata[7:0] = rx_mem[rx_rd_r];
    end
    else if (hit(paddr, spi_fifo_port_pkg::OFF_TX_MARK))
      rdata[2:0] = tx_mark_r;
    else if (hit(paddr, spi_fifo_port_pkg::OFF_RX_MARK))
      rdata[2:0] = rx_mark_r;
    else if (hit(paddr, spi_fifo_port_pkg::OFF_LEVEL_STAT))
      rdata[1:0] = {rx_level, tx_level};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      io_line_o <= 4'h0;
      io_line_oe <= 4'h0;
      tx_level <= 1'b0;
      rx_level <= 1'b0;
    end
    else
    begin
      // One wait state: answer registered, completes second access cycle
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      prdata <= rdata;
      io_line_o <= drv_nxt.o;
      io_line_oe <= drv_nxt.oe;
      tx_level <= (tx_cnt_r < {1'b0, tx_mark_r});
      rx_level <= (rx_cnt_r > {1'b0, rx_mark_r});
    end
  end
endmodule // spi_frame_format_fifo_port
`default_nettype wire

// >>> dv/spi_fifo_port_props.sv
// Checker: bus answer and read-back properties of the FIFO port
`default_nettype none
module spi_fifo_port_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Line enables
  input wire logic [3:0] io_line_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic rd;
  assign rd = pready && psel && !pwrite;
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_done;
    ##[1:4] pready;
  endsequence
  a_access_answered: assert property (s_wait |-> s_done)
    else $error("access not answered in time");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_data_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer with data");
  a_tx_reads_zero: assert property (rd &&
    paddr == spi_fifo_port_pkg::OFF_TX_PORT |-> prdata[7:0] == 8'h0)
    else $error("transmit port data not zero");
  a_txmark_width: assert property (rd &&
    paddr == spi_fifo_port_pkg::OFF_TX_MARK |-> prdata[31:3] == 29'h0)
    else $error("transmit mark wider than three bits");
  a_rxmark_width: assert property (rd &&
    paddr == spi_fifo_port_pkg::OFF_RX_MARK |-> prdata[31:3] == 29'h0)
    else $error("receive mark wider than three bits");
  a_len_legal: assert property (rd && paddr ==
    spi_fifo_port_pkg::OFF_FRAME_SHAPE |-> prdata[19:16] <= 4'h8)
    else $error("frame length above eight");
  a_oe_lane_set: assert property (io_line_oe inside
    {4'h0, 4'h1, 4'h3, 4'hf})
    else $error("line enables outside a lane set");
endmodule // spi_fifo_port_props
bind spi_frame_format_fifo_port spi_fifo_port_props u_spi_fifo_port_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .io_line_oe(io_line_oe));
`default_nettype wire

// >>> dv/spi_dev_model.sv
// Far-side serial device: replies a fixed byte, captures line 0
`default_nettype none
module spi_dev_model #(
  parameter logic [7:0] REPLY = 8'ha5
) (
  // Link
  input wire logic sck,
  input wire logic act,
  // Data lines
  input wire logic [3:0] line_in,
  output logic [3:0] line_out,
  // Captured byte
  output logic [7:0] got
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh = 8'h0;
  logic lst = 1'b0;
  initial got = 8'h0;
  always @(posedge act) sh = REPLY;
  always @(negedge sck)
  begin
    lst = sh[7];
    sh = {sh[6:0], 1'b0};
  end
  // Single lane: host data arrives on line 0
  always @(posedge sck) got = {got[6:0], line_in[0]};
  // Released lines flip away from the last bit so stale data never matches
  assign line_out = act ? {4{sh[7]}} : {4{~lst}};
endmodule // spi_dev_model
`default_nettype wire

// >>> dv/tb_top.sv
// Testbench: register port, FIFOs and frame format scenarios
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic sck_in, frame_go, flash_path, act, tx_level, rx_level;
  logic [7:0] paddr, got;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] lo, loe, dev_o, wv, oe_s;
  logic [3:0] oe_exp [2][3] = '{'{4'h1, 4'h0, 4'h0}, '{4'h1, 4'h3, 4'hf}};
  int err_count, n_checks;
  assign wv = (loe & lo) | (~loe & dev_o);
  spi_frame_format_fifo_port u_spi_frame_format_fifo_port (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sck_in(sck_in),
    .frame_go(frame_go), .flash_path(flash_path), .io_line_i(wv),
    .io_line_o(lo), .io_line_oe(loe), .tx_level(tx_level),
    .rx_level(rx_level));
  spi_dev_model u_spi_dev_model (.sck(sck_in), .act(act), .line_in(wv),
    .line_out(dev_o), .got(got));
  // *****
  // Clock, bus and link tasks
  // *****
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict;
    if (err_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a stalled access
    while (pready !== 1'b1)
      @(posedge pclk);
    chk("pready", pready, 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Serial clock only toggles inside a frame
  task automatic frame(input int n);
    act <= 1'b1;
    frame_go <= 1'b1;
    @(posedge pclk);
    frame_go <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      repeat (4) @(posedge pclk);
      sck_in <= 1'b1;
      repeat (4) @(posedge pclk);
      if (i == 0) oe_s = loe;
      sck_in <= 1'b0;
    end
    repeat (8) @(posedge pclk);
    act <= 1'b0;
  endtask
  // *****
  // Scenarios
  // *****
  task automatic t_reset;
    apb(0, spi_fifo_port_pkg::OFF_FRAME_SHAPE, 0);
    chk("format reset", r, 32'h0008_0008);
    apb(0, spi_fifo_port_pkg::OFF_TX_MARK, 0);
    chk("tx mark reset", r, 32'h1);
    apb(0, spi_fifo_port_pkg::OFF_RX_MARK, 0);
    chk("rx mark reset", r, 32'h0);
    apb(0, spi_fifo_port_pkg::OFF_RX_PORT, 0);
    chk("rx empty", r[31], 1'b1);
    chk("tx level", tx_level, 1'b1);
    apb(0, 8'h7c, 0);
    chk("unmapped error", e, 1'b1);
  endtask
  task automatic t_fill;
    apb(1, spi_fifo_port_pkg::OFF_TX_PORT, 32'h10);
    repeat (2) @(posedge pclk);
    chk("tx level one entry", tx_level, 1'b0);
    for (int i = 1; i < 9; i++)
      apb(1, spi_fifo_port_pkg::OFF_TX_PORT, 32'h10 + i);
    apb(0, spi_fifo_port_pkg::OFF_TX_PORT, 0);
    chk("tx full read", r, 32'h8000_0000);
    flash_path <= 1'b1;
    frame(8);
    flash_path <= 1'b0;
    apb(0, spi_fifo_port_pkg::OFF_TX_PORT, 0);
    chk("flash path keeps fifo", r[31], 1'b1);
  endtask
  task automatic t_frame;
    apb(1, spi_fifo_port_pkg::OFF_FRAME_SHAPE, 32'h0008_0000);
    frame(8);
    chk("tx bits", got, 8'h10);
    chk("rx level", rx_level, 1'b1);
    apb(0, spi_fifo_port_pkg::OFF_RX_PORT, 0);
    chk("rx frame", r, 32'h0000_00a5);
    repeat (2) @(posedge pclk);
    chk("rx level drained", rx_level, 1'b0);
    apb(0, spi_fifo_port_pkg::OFF_RX_PORT, 0);
    chk("rx empty after pop", r[31], 1'b1);
  endtask
  task automatic t_short;
    apb(1, spi_fifo_port_pkg::OFF_FRAME_SHAPE, 32'h0004_0000);
    frame(4);
    chk("short tx msb", got[3:0], 4'h1);
    apb(0, spi_fifo_port_pkg::OFF_RX_PORT, 0);
    chk("short msb top", r[7:4], 4'ha);
    apb(1, spi_fifo_port_pkg::OFF_FRAME_SHAPE, 32'h0004_0004);
    frame(4);
    chk("short tx lsb", got[3:0], 4'h4);
    apb(0, spi_fifo_port_pkg::OFF_RX_PORT, 0);
    chk("short lsb bottom", r[3:0], 4'h5);
  endtask
  task automatic t_dir;
    apb(1, spi_fifo_port_pkg::OFF_FRAME_SHAPE, 32'h0008_0008);
    frame(8);
    apb(0, spi_fifo_port_pkg::OFF_RX_PORT, 0);
    chk("tx dir stores none", r[31], 1'b1);
    apb(1, spi_fifo_port_pkg::OFF_RX_PORT, 32'h5a);
    apb(0, spi_fifo_port_pkg::OFF_RX_PORT, 0);
    chk("rx write ignored", r[31], 1'b1);
  endtask
  task automatic t_lanes;
    for (int d = 0; d < 2; d++)
      for (int l = 0; l < 3; l++)
      begin
        apb(1, spi_fifo_port_pkg::OFF_TX_PORT, 32'h3c);
        apb(1, spi_fifo_port_pkg::OFF_FRAME_SHAPE,
          {12'h0, 4'h8, 12'h0, d[0], 1'b0, l[1:0]});
        frame(8 >> l);
        chk("line enables", oe_s, oe_exp[d][l]);
      end
  endtask
  task automatic t_marks;
    apb(1, spi_fifo_port_pkg::OFF_TX_MARK, 32'h5);
    apb(0, spi_fifo_port_pkg::OFF_TX_MARK, 0);
    chk("tx mark rw", r, 32'h5);
    apb(1, spi_fifo_port_pkg::OFF_RX_MARK, 32'h3);
    apb(0, spi_fifo_port_pkg::OFF_RX_MARK, 0);
    chk("rx mark rw", r, 32'h3);
  endtask
  initial
  begin
    {psel, penable, pwrite, sck_in, frame_go, flash_path, act} = 7'h0;
    {paddr, pwdata} = 40'h0;
    presetn = 1'b0;
    err_count = 0;
    n_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_fill;
    t_frame;
    t_short;
    t_dir;
    t_lanes;
    t_marks;
    give_verdict;
  end
  // Whole run is under a thousand cycles; this bound leaves wide margin
  initial
  begin
    #2_000_000;
    err_count++;
    give_verdict;
  end
endmodule // tb_top
`default_nettype wire
